// ### sac_pkg.sv
// shared constants for the slot addressed i/o chain extender unit
// assumes a single 20 MHz clock domain and synchronous active-high reset
package sac_pkg;
   // ---------------------------------------------
   // word layout
   // ---------------------------------------------
   localparam int SAC_WORD_W = 16;     // programmed word width
   localparam int SAC_DATA_W = 12;     // data field width
   localparam int SAC_ADDR_W = 4;      // slot address field width
   localparam int SAC_ADDR_LSB = 12;   // address field position
   localparam int SAC_SLOTS = 15;      // card slots per unit
   localparam int SAC_UNITS = 15;      // unit select lines in the chain
   localparam int SAC_FWD_W = 14;      // select lines forwarded downstream
   localparam logic [3:0] SAC_SLOT_BASE = 4'h0; // slot 0 answers to address 0
   // ---------------------------------------------
   // timing
   // ---------------------------------------------
   localparam int SAC_CLK_NS = 50;     // clock period
   localparam int SAC_BUSY_NS = 200;   // busy time after a strobe
   localparam int SAC_BUSY_CYC = (SAC_BUSY_NS + SAC_CLK_NS - 1) / SAC_CLK_NS;
   // ---------------------------------------------
   // sequencer states
   // ---------------------------------------------
   typedef enum logic [1:0] {SAC_IDLE, SAC_BUSY} sac_state_e;
endpackage

// ### sac_slot.sv
// one card slot: address gate, output latch, input storage and read gate
// assumes strobe and data arrive already synchronised to SYS_CLK
`timescale 1ns/1ps
module sac_slot
   import sac_pkg::*;
#(
   parameter logic [SAC_ADDR_W-1:0] SLOT_ADDR = SAC_SLOT_BASE,
   parameter int DW = SAC_DATA_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic unit_sel,
   input wire logic strobe,
   input wire logic in_mode,
   input wire logic [SAC_ADDR_W-1:0] addr,
   input wire logic [DW-1:0] wdata,
   input wire logic storage_en,
   input wire logic ext_valid,
   input wire logic [DW-1:0] ext_data,
   input wire logic accept,
   output logic [DW-1:0] out_val,
   output logic [DW-1:0] rd_data,
   output logic rd_en,
   output logic held
);
   // ---------------------------------------------
   // address gate and storage
   // ---------------------------------------------
   logic hit;             // unit and slot both addressed
   logic [DW-1:0] cap;    // stored input sample
   logic [DW-1:0] next_out_val;
   logic [DW-1:0] next_cap;
   logic next_held;

   assign hit = unit_sel && (addr == SLOT_ADDR);

   // next-state for latch and capture
   always_comb begin
      next_out_val = out_val;
      next_cap = cap;
      next_held = held;
      if (strobe && hit && !in_mode) begin
         next_out_val = wdata;
      end
      // capture once, hold until the host accepts it at this address
      if (ext_valid && !held) begin
         next_cap = ext_data;
         next_held = storage_en;
      end else if (held && accept && hit && in_mode) begin
         next_held = 1'b0;
      end
   end

   // registers
   always_ff @(posedge clk) begin
      if (rst) begin
         out_val <= '0;
         cap <= '0;
         held <= 1'b0;
      end else begin
         out_val <= next_out_val;
         cap <= next_cap;
         held <= next_held;
      end
   end

   // read gate: only this card drives the shared bus when addressed in input mode
   assign rd_en = hit && in_mode;
   assign rd_data = (storage_en && held) ? cap : ext_data;
endmodule

// ### sac_unit.sv
// What this block does
// - 16-bit word: 12 data, 4 slot address
// - output card holds value until readdressed
// - input cards decode same four slot bits
// - input data driven only when addressed, input mode
// - fixed unique slot address, unit and slot
// - storage option keeps input until accepted
// - input mode puts card data upstream
// - steer data by input-mode control
// - busy/ready flag returned upstream
// - use first select, forward remaining fourteen shifted
// - unit select partial, next word completes
// - up to fifteen extenders, 225 channels
// - unit selection held until changed upstream
// - bits 12-15 fan out as address
//
// extender unit top: chain connector in, chain connector out, 15 slots
// assumes all chain inputs are asynchronous and are synchronised here
`timescale 1ns/1ps
module sac_unit
   import sac_pkg::*;
#(
   parameter int NSLOT = SAC_SLOTS,
   parameter int DW = SAC_DATA_W
) (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic [SAC_WORD_W-1:0] UP_WORD,
   input wire logic [SAC_UNITS-1:0] UP_UNIT_SEL,
   input wire logic UP_IN_MODE,
   input wire logic UP_STROBE,
   input wire logic UP_ACCEPT,
   output logic [SAC_WORD_W-1:0] UP_RET_WORD,
   output logic UP_RET_FLAG,
   output logic [SAC_WORD_W-1:0] DN_WORD,
   output logic [SAC_UNITS-1:0] DN_UNIT_SEL,
   output logic DN_IN_MODE,
   output logic DN_STROBE,
   output logic DN_ACCEPT,
   input wire logic [SAC_WORD_W-1:0] DN_RET_WORD,
   input wire logic DN_RET_FLAG,
   input wire logic [NSLOT-1:0] CARD_STORAGE_EN,
   input wire logic [NSLOT-1:0] CARD_EXT_VALID,
   input wire logic [NSLOT*DW-1:0] CARD_EXT_DATA,
   output logic [NSLOT*DW-1:0] CARD_OUT
);
   // ---------------------------------------------
   // pin synchronisers: three stages, change when 2 and 3 agree
   // ---------------------------------------------
   localparam int CW = SAC_WORD_W + SAC_UNITS + 4;        // chain word and control bits
   localparam int SW = CW + SAC_WORD_W + NSLOT * (DW + 2); // plus return word and card pins
   logic [SW-1:0] s1, s2, s3, q;   // s1 read only by s2
   logic [SW-1:0] next_q;
   logic [SW-1:0] pin_bus;

   // card pins and the downstream return are far-side levels too, so they share the filter
   assign pin_bus = {CARD_EXT_DATA, CARD_EXT_VALID, CARD_STORAGE_EN, DN_RET_WORD,
      UP_WORD, UP_UNIT_SEL, UP_IN_MODE, UP_STROBE, UP_ACCEPT, DN_RET_FLAG};

   // filtered value follows only a stable pair
   always_comb begin
      next_q = q;
      for (int i = 0; i < SW; i++) begin
         if (s2[i] == s3[i]) begin
            next_q[i] = s3[i];
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         q <= '0;
      end else begin
         s1 <= pin_bus;
         s2 <= s1;
         s3 <= s2;
         q <= next_q;
      end
   end

   // ---------------------------------------------
   // decoded chain signals
   // ---------------------------------------------
   logic [SAC_WORD_W-1:0] word;      // buffered programmed word
   logic [SAC_UNITS-1:0] usel;       // buffered unit select lines
   logic in_mode;                    // input mode from master
   logic strobe_lvl, strobe_d;       // word strobe level and delay
   logic strobe;                     // one-cycle strobe pulse
   logic accept;                     // host has taken input data
   logic dn_flag;                    // downstream busy flag
   logic [SAC_ADDR_W-1:0] addr;
   logic [SAC_WORD_W-1:0] dn_ret;    // filtered downstream return word
   logic [NSLOT-1:0] card_st;        // filtered storage option straps
   logic [NSLOT-1:0] card_vld;       // filtered external data present
   logic [NSLOT*DW-1:0] card_ext;    // filtered external card data

   assign dn_ret = q[CW +: SAC_WORD_W];
   assign card_st = q[CW + SAC_WORD_W +: NSLOT];
   assign card_vld = q[CW + SAC_WORD_W + NSLOT +: NSLOT];
   assign card_ext = q[CW + SAC_WORD_W + 2 * NSLOT +: NSLOT * DW];
   assign word = q[CW-1 -: SAC_WORD_W];
   assign usel = q[4 +: SAC_UNITS];
   assign in_mode = q[3];
   assign strobe_lvl = q[2];
   assign accept = q[1];
   assign dn_flag = q[0];
   assign addr = word[SAC_ADDR_LSB +: SAC_ADDR_W];
   assign strobe = strobe_lvl && !strobe_d;

   // ---------------------------------------------
   // busy/ready sequencer
   // ---------------------------------------------
   sac_state_e state, next_state;
   logic [7:0] cnt, next_cnt;        // busy cycles left

   // start busy on a strobe seen while idle, release after the fixed time
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      case (state)
         SAC_IDLE: begin
            if (strobe) begin
               next_state = SAC_BUSY;
               next_cnt = 8'(SAC_BUSY_CYC - 1);
            end
         end
         SAC_BUSY: begin
            if (cnt == 8'h00) begin
               next_state = SAC_IDLE;
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
         default: begin
            next_state = SAC_IDLE;
            next_cnt = 8'h00;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         state <= SAC_IDLE;
         cnt <= 8'h00;
         strobe_d <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         strobe_d <= strobe_lvl;
      end
   end

   // ---------------------------------------------
   // card slots, one per wired address
   // ---------------------------------------------
   logic [NSLOT*DW-1:0] rd_flat;
   logic [NSLOT-1:0] rd_en;
   logic own_sel;                    // first select line enables this unit

   // selection holds as long as the master keeps the line up
   assign own_sel = usel[0];

   generate
      for (genvar g = 0; g < NSLOT; g++) begin : g_slot
         sac_slot #(
            .SLOT_ADDR(SAC_ADDR_W'(g) + SAC_SLOT_BASE),
            .DW(DW)
         ) u_slot (
            .clk(SYS_CLK),
            .rst(SYS_RST),
            .unit_sel(own_sel),
            .strobe(strobe),
            .in_mode(in_mode),
            .addr(addr),
            .wdata(word[DW-1:0]),
            .storage_en(card_st[g]),
            .ext_valid(card_vld[g]),
            .ext_data(card_ext[g*DW +: DW]),
            .accept(accept),
            .out_val(CARD_OUT[g*DW +: DW]),
            .rd_data(rd_flat[g*DW +: DW]),
            .rd_en(rd_en[g]),
            .held()
         );
      end
   endgenerate

   // ---------------------------------------------
   // return path steering
   // ---------------------------------------------
   logic [DW-1:0] rd_mux;            // wired-or of the one enabled slot
   logic [SAC_WORD_W-1:0] next_ret;
   logic next_flag;

   // combine slot reads; unmatched address leaves zero
   always_comb begin
      rd_mux = '0;
      for (int i = 0; i < NSLOT; i++) begin
         if (rd_en[i]) begin
            rd_mux = rd_mux | rd_flat[i*DW +: DW];
         end
      end
   end

   // in input mode own card data replaces programmed data, else pass downstream return; output mode returns the programmed word
   always_comb begin
      next_ret = word;
      if (in_mode) begin
         if (own_sel) begin
            next_ret = {word[SAC_WORD_W-1 -: SAC_ADDR_W], rd_mux};
         end else begin
            next_ret = dn_ret;
         end
      end
      next_flag = (state == SAC_BUSY) || dn_flag;
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         UP_RET_WORD <= '0;
         UP_RET_FLAG <= 1'b0;
         DN_WORD <= '0;
         DN_UNIT_SEL <= '0;
         DN_IN_MODE <= 1'b0;
         DN_STROBE <= 1'b0;
         DN_ACCEPT <= 1'b0;
      end else begin
         UP_RET_WORD <= next_ret;
         UP_RET_FLAG <= next_flag;
         DN_WORD <= word;
         DN_UNIT_SEL <= {1'b0, usel[SAC_FWD_W:1]};
         DN_IN_MODE <= in_mode;
         DN_STROBE <= strobe_lvl;
         DN_ACCEPT <= accept;
      end
   end
endmodule

// ### sac_unit_sva.sv
// checker: port-level timing relations of one extender unit
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module sac_unit_sva
   import sac_pkg::*;
#(
   parameter int NSLOT = SAC_SLOTS,
   parameter int DW = SAC_DATA_W
) (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic [SAC_WORD_W-1:0] UP_WORD,
   input wire logic [SAC_UNITS-1:0] UP_UNIT_SEL,
   input wire logic UP_IN_MODE,
   input wire logic UP_STROBE,
   input wire logic [SAC_WORD_W-1:0] UP_RET_WORD,
   input wire logic UP_RET_FLAG,
   input wire logic [SAC_WORD_W-1:0] DN_WORD,
   input wire logic [SAC_UNITS-1:0] DN_UNIT_SEL,
   input wire logic DN_IN_MODE,
   input wire logic [SAC_WORD_W-1:0] DN_RET_WORD,
   input wire logic DN_RET_FLAG,
   input wire logic [NSLOT*DW-1:0] CARD_OUT
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   // strobe over, nothing busy downstream
   sequence s_done;
      $fell(UP_STROBE) ##1 (!UP_STROBE && !DN_RET_FLAG) [*8];
   endsequence
   property p_fwd_sel;
      $stable(UP_UNIT_SEL) [*8] |-> DN_UNIT_SEL == {1'h0, UP_UNIT_SEL[14:1]};
   endproperty
   a_fwd_sel: assert property (p_fwd_sel) else $error("bad select shift");
   property p_fwd_word;
      $stable(UP_WORD) [*8] |-> DN_WORD == UP_WORD;
   endproperty
   a_fwd_word: assert property (p_fwd_word) else $error("bad word copy");
   property p_fwd_mode;
      $stable(UP_IN_MODE) [*8] |-> DN_IN_MODE == UP_IN_MODE;
   endproperty
   a_fwd_mode: assert property (p_fwd_mode) else $error("bad mode copy");
   property p_busy_rise;
      $rose(UP_STROBE) |-> ##[3:8] UP_RET_FLAG;
   endproperty
   a_busy_rise: assert property (p_busy_rise) else $error("no busy");
   property p_busy_end;
      s_done |-> !UP_RET_FLAG;
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("busy stuck");
   property p_busy_dn;
      DN_RET_FLAG [*6] |-> UP_RET_FLAG;
   endproperty
   a_busy_dn: assert property (p_busy_dn) else $error("busy not passed");
   property p_hold;
      !UP_STROBE [*8] |-> $stable(CARD_OUT);
   endproperty
   a_hold: assert property (p_hold) else $error("card moved");
   property p_in_hold;
      UP_IN_MODE [*8] |-> $stable(CARD_OUT);
   endproperty
   a_in_hold: assert property (p_in_hold) else $error("write in input");
   property p_unsel;
      !UP_UNIT_SEL[0] [*8] |-> $stable(CARD_OUT);
   endproperty
   a_unsel: assert property (p_unsel) else $error("unselected write");
   property p_pass;
      (UP_IN_MODE && !UP_UNIT_SEL[0] && $stable(DN_RET_WORD)) [*8] |-> UP_RET_WORD == DN_RET_WORD;
   endproperty
   a_pass: assert property (p_pass) else $error("return not passed");
endmodule
bind sac_unit sac_unit_sva #(.NSLOT(NSLOT), .DW(DW)) u_sva (.SYS_CLK(SYS_CLK),
   .SYS_RST(SYS_RST), .UP_WORD(UP_WORD), .UP_UNIT_SEL(UP_UNIT_SEL), .UP_IN_MODE(UP_IN_MODE),
   .UP_STROBE(UP_STROBE), .UP_RET_WORD(UP_RET_WORD), .UP_RET_FLAG(UP_RET_FLAG),
   .DN_WORD(DN_WORD), .DN_UNIT_SEL(DN_UNIT_SEL), .DN_IN_MODE(DN_IN_MODE),
   .DN_RET_WORD(DN_RET_WORD),
   .DN_RET_FLAG(DN_RET_FLAG), .CARD_OUT(CARD_OUT));

// ### sac_down_model.sv
// next extender in the chain: busy flag and input return
// assumes the unit's downstream outputs feed it
`timescale 1ns/1ps
module sac_down_model
   import sac_pkg::*;
(
   input wire logic clk,
   input wire logic slow,
   input wire logic [SAC_WORD_W-1:0] word,
   input wire logic [SAC_UNITS-1:0] sel,
   input wire logic in_mode,
   input wire logic strobe,
   output logic [SAC_WORD_W-1:0] ret_word,
   output logic ret_flag
);
   logic prev = 1'h0;
   int busy = 0;
   logic [15:0] junk = 16'h0;
   // busy after an addressed strobe, short or long
   always @(posedge clk) begin
      prev <= strobe;
      junk <= ~junk;
      if (strobe && !prev && sel[0]) busy <= slow ? 20 : 2;
      else if (busy > 0) busy <= busy - 1;
   end
   assign ret_flag = busy != 0;
   // undriven return toggles so nothing stale passes
   assign ret_word = (in_mode && sel[0]) ? {word[15:12], 12'hA50 ^ {8'h0, word[15:12]}} : junk;
endmodule

// ### sac_unit_tb.sv
// self-checking bench for one extender unit
// assumes the downstream model stands at the chain output
`timescale 1ns/1ps
module sac_unit_tb;
   import sac_pkg::*;
   logic clk = 1'h0, rst = 1'h1, mode = 1'h0, stb = 1'h0, acc = 1'h0, slow = 1'h0;
   logic [15:0] word = 16'h0, ret, dw, drw;
   logic [14:0] sel = 15'h0, ds, st = 15'h8, vld = 15'h7FF7;
   logic dm, dst, flag, dfl, dac;
   logic [179:0] ext = 180'h0, co;
   logic [11:0] eo[15], ei[15];
   int failures = 0, num_checks = 0, cyc = 0;
   logic [3:0] a;
   sac_unit DUT (.SYS_CLK(clk), .SYS_RST(rst), .UP_WORD(word), .UP_UNIT_SEL(sel),
      .UP_IN_MODE(mode), .UP_STROBE(stb), .UP_ACCEPT(acc), .UP_RET_WORD(ret),
      .UP_RET_FLAG(flag), .DN_WORD(dw), .DN_UNIT_SEL(ds), .DN_IN_MODE(dm), .DN_STROBE(dst),
      .DN_ACCEPT(dac), .DN_RET_WORD(drw), .DN_RET_FLAG(dfl), .CARD_STORAGE_EN(st),
      .CARD_EXT_VALID(vld), .CARD_EXT_DATA(ext), .CARD_OUT(co));
   sac_down_model u_dn (.clk(clk), .slow(slow), .word(dw), .sel(ds), .in_mode(dm),
      .strobe(dst), .ret_word(drw), .ret_flag(dfl));
   always #25 clk = ~clk;
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         failures++;
         summarize();
      end
   end
   task summarize;
      if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task check(input string n, input logic [15:0] e, input logic [15:0] s);
      num_checks++;
      if (e !== s) begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   // own-unit read: address echo over card data, nothing for the empty address
   function automatic logic [15:0] rd_exp(input logic [3:0] ad);
      return {ad, ((ad == 4'hF) ? 12'h0 : ei[ad])};
   endfunction
   // return handed up by the next unit's model
   function automatic logic [15:0] chain_exp(input logic [3:0] ad);
      return {ad, 12'hA50 ^ {8'h0, ad}};
   endfunction
   // one word: set, strobe three cycles, wait out busy
   task op(input logic [3:0] ad, input logic [11:0] d, input logic [14:0] s, input logic m);
      int n;
      @(negedge clk);
      word = {ad, d};
      sel = s;
      mode = m;
      @(negedge clk);
      stb = 1'h1;
      repeat (3) @(negedge clk);
      stb = 1'h0;
      repeat (8) @(negedge clk);
      n = 0;
      while (flag !== 1'h0 && n < 60) begin
         @(negedge clk);
         n++;
      end
      check("busy", 16'h0, {15'h0, flag});
      if (!m && s[0] && ad != 4'hF) eo[ad] = d;
      if (m && s[0]) check("read", rd_exp(ad), ret);
      if (m && !s[0] && s[1]) check("chain", chain_exp(ad), ret);
   endtask
   task cards;
      for (int g = 0; g < 15; g++) check("card", {4'h0, eo[g]}, {4'h0, co[g*12+:12]});
   endtask
   initial begin
      void'($urandom(32'h9D1B));
      for (int g = 0; g < 15; g++) begin
         ext[g*12+:12] = 12'($urandom);
         ei[g] = ext[g*12+:12];
         eo[g] = 12'h0;
      end
      repeat (6) @(negedge clk);
      rst = 1'h0;
      // slot 3 sees its data only briefly; storage must keep the first value
      vld[3] = 1'h1;
      repeat (3) @(negedge clk);
      vld[3] = 1'h0;
      ext[36+:12] = ~ei[3];
      foreach (eo[g]) op(4'(g), 12'hFFF - 12'(g), 15'h1, 1'h0);
      op(4'hF, 12'hABC, 15'h1, 1'h0);
      cards();
      for (int i = 0; i < 60; i++) begin
         slow = 1'($urandom);
         a = 4'($urandom);
         op(a, 12'($urandom), 15'($urandom), 1'($urandom));
      end
      cards();
      op(4'h3, 12'h0, 15'h1, 1'h1);
      acc = 1'h1;
      repeat (5) @(negedge clk);
      check("fwd accept", 16'h1, {15'h0, dac});
      acc = 1'h0;
      repeat (10) @(negedge clk);
      ei[3] = ext[36+:12];
      op(4'h3, 12'h0, 15'h1, 1'h1);
      summarize();
   end
endmodule
